// ### hw/ssb_status_bank.sv
// spi status register bank of a seven channel gate pre-driver
//
// Behaviour
// - top three frame bits carry register address
// - unused address returns twelve zero data bits
// - normal mode flag sits below address
// - flags latch until cause gone and read
// - health bit 11 shows test mode
// - health bit 10 set after entering normal
// - cleared flag resets after health register read
// - bit 9 mirrors failsafe, bit 8 frame error
// - pump low bit 7, pump fail blocks high
// - bit 5 supply under, bit 4 over
// - bit 1 overload summary, bits 3,2,0 zero
// - register 1 gives live gate levels 6..1
// - register 2 holds channel 7 bits
// - register 3 holds overload flags 6..1
// - calibration ready set, cleared by read
// - rising delay result in bits 7:6
// - rising precharge result in bits 5:4
// - falling delay result in bits 3:2
// - falling precharge result in bits 1:0
module ssb_status_bank #(
    parameter logic [11:0] DEVICE_ID = 12'h5A3 // arbitrary value
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    input wire logic FAILSAFE_PIN,
    input wire logic NORMAL_MODE,
    input wire logic TEST_MODE,
    input wire logic PUMP_LOW,
    input wire logic PUMP_FAIL,
    input wire logic SUPPLY_UNDER,
    input wire logic SUPPLY_OVER,
    input wire logic [6:0] GATE_HIGH,
    input wire logic [6:0] GATE_LOW,
    input wire logic [6:0] HIGH_SIDE_OVERLOAD,
    input wire logic [6:0] LOW_SIDE_OVERLOAD,
    input wire logic CAL_DONE,
    input wire logic [1:0] CAL_RISE_DELAY,
    input wire logic [1:0] CAL_RISE_PRECHARGE,
    input wire logic [1:0] CAL_FALL_DELAY,
    input wire logic [1:0] CAL_FALL_PRECHARGE,
    input wire logic [11:0] OUTPUT_STATUS,
    input wire logic [2:0] STATUS_SELECT,
    input wire logic STATUS_SELECT_HOLD,
    input wire logic STATUS_SELECT_WR,
    output logic HIGH_SIDE_BLOCK,
    output logic [15:0] RX_WORD,
    output logic RX_STROBE
);

    typedef enum logic {
        SSB_IDLE,
        SSB_FRAME
    } ssb_state_e;

    ssb_state_e state_q;
    logic [3:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic failsafe_s;
    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic frame_good;
    logic frame_bad;
    logic [4:0] cnt_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic [2:0] sel_q;
    logic hold_q;
    logic [2:0] sent_addr_q;
    logic [11:0] sent_data_q;
    logic normal_prev_q;
    logic normal_entry;
    logic [11:0] data_mux;
    logic [13:0] gate_pairs;
    logic [13:0] ovl_set;
    logic [13:0] ovl_clr;
    logic [13:0] ovl_flags;
    logic [5:0] health_set;
    logic [5:0] health_clr;
    logic [5:0] health_flags;
    logic cal_ready;
    logic cal_clr;
    logic [1:0] rise_dly_q;
    logic [1:0] rise_pc_q;
    logic [1:0] fall_dly_q;
    logic [1:0] fall_pc_q;
    logic summary;
    logic read_health;
    logic read_ch7;
    logic read_ovl;
    logic read_cal;
    logic oe_q;
    logic rx_strobe_q;

    // spi pins and failsafe pin cross into the clock domain
    ssb_sync #(
        .W(4)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .async_in({FAILSAFE_PIN, SPI_SDI, ~SPI_CS_N, SPI_SCLK}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign cs_n_s = ~pins_s[1]; // inverted so reset reads deselected
    assign sdi_s = pins_s[2];
    assign failsafe_s = pins_s[3];

    // edge detection on the synchronised link clock
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign frame_start = (state_q == SSB_IDLE) & ~cs_n_s;
    assign frame_end = (state_q == SSB_FRAME) & cs_n_s;
    assign frame_good = frame_end & (cnt_q == ssb_pkg::FRAME_BITS);
    assign frame_bad = frame_end & (cnt_q != ssb_pkg::FRAME_BITS);

    // frame state
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            state_q <= SSB_IDLE;
        end else begin
            case (state_q)
                SSB_IDLE: begin
                    if (frame_start) begin
                        state_q <= SSB_FRAME;
                    end
                end
                SSB_FRAME: begin
                    if (frame_end) begin
                        state_q <= SSB_IDLE;
                    end
                end
                default: begin
                    state_q <= SSB_IDLE;
                end
            endcase
        end
    end

    // count of rising clock edges in the frame, saturating
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            cnt_q <= 5'h00;
        end else if (frame_start) begin
            cnt_q <= 5'h00;
        end else if (state_q == SSB_FRAME && sclk_rise &&
                     cnt_q != ssb_pkg::CNT_MAX) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // output shift register, msb first, changes on falling edge
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            tx_q <= ssb_pkg::FRAME_RESET;
        end else if (frame_start) begin
            tx_q <= {sel_q, NORMAL_MODE, data_mux};
        end else if (state_q == SSB_FRAME && sclk_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end else if (state_q == SSB_IDLE) begin
            tx_q <= ssb_pkg::FRAME_RESET;
        end
    end

    // data output enabled while chip select is low
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= frame_start | ((state_q == SSB_FRAME) & ~frame_end);
        end
    end

    assign SPI_SDO = tx_q[15];
    assign SPI_SDO_OE = oe_q;

    // input shift register sampled on rising edge
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rx_q <= ssb_pkg::FRAME_RESET;
        end else if (state_q == SSB_FRAME && sclk_rise) begin
            rx_q <= {rx_q[14:0], sdi_s};
        end
    end

    // received word handed on after a complete frame
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            RX_WORD <= ssb_pkg::FRAME_RESET;
            rx_strobe_q <= 1'b0;
        end else begin
            rx_strobe_q <= frame_good;
            if (frame_good) begin
                RX_WORD <= rx_q;
            end
        end
    end

    assign RX_STROBE = rx_strobe_q;

    // snapshot of what the frame reports, used for clear on read
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sent_addr_q <= ssb_pkg::SELECT_RESET;
            sent_data_q <= ssb_pkg::DATA_RESET;
        end else if (frame_start) begin
            sent_addr_q <= sel_q;
            sent_data_q <= data_mux;
        end
    end

    // register selection; single reads fall back to health register
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sel_q <= ssb_pkg::SELECT_RESET;
            hold_q <= 1'b0;
        end else if (STATUS_SELECT_WR) begin
            sel_q <= STATUS_SELECT;
            hold_q <= STATUS_SELECT_HOLD;
        end else if (frame_good && !hold_q) begin
            sel_q <= ssb_pkg::ADDR_HEALTH;
        end
    end

    // normal mode entry detection
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            normal_prev_q <= 1'b0;
        end else begin
            normal_prev_q <= NORMAL_MODE;
        end
    end

    assign normal_entry = NORMAL_MODE & ~normal_prev_q;

    // which register a completed frame has read
    assign read_health = frame_good & (sent_addr_q == ssb_pkg::ADDR_HEALTH);
    assign read_ch7 = frame_good & (sent_addr_q == ssb_pkg::ADDR_CH7);
    assign read_ovl = frame_good & (sent_addr_q == ssb_pkg::ADDR_OVERLOAD);
    assign read_cal = frame_good & (sent_addr_q == ssb_pkg::ADDR_CAL);

    // health flags: cleared flag, frame error, pump, supply
    assign health_set = {normal_entry, frame_bad, PUMP_LOW, PUMP_FAIL,
                         SUPPLY_UNDER, SUPPLY_OVER};
    assign health_clr = {6{read_health}} &
                        {sent_data_q[ssb_pkg::CLEARED_BIT],
                         sent_data_q[ssb_pkg::FRAME_ERR_BIT],
                         sent_data_q[ssb_pkg::PUMP_LOW_BIT],
                         sent_data_q[ssb_pkg::PUMP_FAIL_BIT],
                         sent_data_q[ssb_pkg::UNDER_BIT],
                         sent_data_q[ssb_pkg::OVER_BIT]};

    ssb_flag_bank #(
        .W(ssb_pkg::HEALTH_W)
    ) u_health (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .set(health_set),
        .clr(health_clr),
        .flags(health_flags)
    );

    // pump failure blocks high-side pre-driver activation
    assign HIGH_SIDE_BLOCK = health_flags[2];

    // per channel high/low pairs, high side in the upper bit
    genvar ch;
    generate
        for (ch = 0; ch < 7; ch++) begin : g_pair
            assign gate_pairs[2*ch+1] = GATE_HIGH[ch];
            assign gate_pairs[2*ch] = GATE_LOW[ch];
            assign ovl_set[2*ch+1] = HIGH_SIDE_OVERLOAD[ch];
            assign ovl_set[2*ch] = LOW_SIDE_OVERLOAD[ch];
        end
    endgenerate

    // overload flags of channels 1..6 clear by register 3,
    // channel 7 by register 2, each only where it was reported
    assign ovl_clr = {{2{read_ch7}} &
                      sent_data_q[ssb_pkg::CH7_HS_OVL_BIT:
                                  ssb_pkg::CH7_LS_OVL_BIT],
                      {12{read_ovl}} & sent_data_q};

    ssb_flag_bank #(
        .W(ssb_pkg::OVL_W)
    ) u_overload (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .set(ovl_set),
        .clr(ovl_clr),
        .flags(ovl_flags)
    );

    assign summary = |ovl_flags;

    // calibration results captured when a calibration completes
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rise_dly_q <= ssb_pkg::CAL_RESET;
            rise_pc_q <= ssb_pkg::CAL_RESET;
            fall_dly_q <= ssb_pkg::CAL_RESET;
            fall_pc_q <= ssb_pkg::CAL_RESET;
        end else if (CAL_DONE) begin
            rise_dly_q <= CAL_RISE_DELAY;
            rise_pc_q <= CAL_RISE_PRECHARGE;
            fall_dly_q <= CAL_FALL_DELAY;
            fall_pc_q <= CAL_FALL_PRECHARGE;
        end
    end

    // ready flag cleared after a read that reported it
    assign cal_clr = read_cal & sent_data_q[ssb_pkg::CAL_READY_BIT];

    ssb_flag_bank #(
        .W(1)
    ) u_cal_ready (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .set(CAL_DONE),
        .clr(cal_clr),
        .flags(cal_ready)
    );

    // data field of the selected register
    always_comb begin
        data_mux = ssb_pkg::DATA_RESET;
        case (sel_q)
            ssb_pkg::ADDR_HEALTH: begin
                data_mux[ssb_pkg::TEST_BIT] = TEST_MODE;
                data_mux[ssb_pkg::CLEARED_BIT] = health_flags[5];
                data_mux[ssb_pkg::FAILSAFE_BIT] = failsafe_s;
                data_mux[ssb_pkg::FRAME_ERR_BIT] = health_flags[4];
                data_mux[ssb_pkg::PUMP_LOW_BIT] = health_flags[3];
                data_mux[ssb_pkg::PUMP_FAIL_BIT] = health_flags[2];
                data_mux[ssb_pkg::UNDER_BIT] = health_flags[1];
                data_mux[ssb_pkg::OVER_BIT] = health_flags[0];
                data_mux[ssb_pkg::SUMMARY_BIT] = summary;
            end
            ssb_pkg::ADDR_GATE_LEVEL: begin
                data_mux = gate_pairs[11:0];
            end
            ssb_pkg::ADDR_CH7: begin
                data_mux[ssb_pkg::CH7_HS_OVL_BIT] = ovl_flags[13];
                data_mux[ssb_pkg::CH7_LS_OVL_BIT] = ovl_flags[12];
                data_mux[ssb_pkg::CH7_HIGH_BIT] = GATE_HIGH[6];
                data_mux[ssb_pkg::CH7_LOW_BIT] = GATE_LOW[6];
            end
            ssb_pkg::ADDR_OVERLOAD: begin
                data_mux = ovl_flags[11:0];
            end
            ssb_pkg::ADDR_CAL: begin
                data_mux[ssb_pkg::CAL_READY_BIT] = cal_ready;
                data_mux[ssb_pkg::RISE_DLY_LSB+:2] = rise_dly_q;
                data_mux[ssb_pkg::RISE_PC_LSB+:2] = rise_pc_q;
                data_mux[ssb_pkg::FALL_DLY_LSB+:2] = fall_dly_q;
                data_mux[ssb_pkg::FALL_PC_LSB+:2] = fall_pc_q;
            end
            ssb_pkg::ADDR_SWITCH_NODE: begin
                data_mux = OUTPUT_STATUS;
            end
            ssb_pkg::ADDR_UNUSED: begin
                data_mux = ssb_pkg::DATA_RESET;
            end
            ssb_pkg::ADDR_IDENT: begin
                data_mux = TEST_MODE ? ssb_pkg::DATA_RESET : DEVICE_ID;
            end
            default: begin
                data_mux = ssb_pkg::DATA_RESET;
            end
        endcase
    end

endmodule : ssb_status_bank

// ### hw/ssb_pkg.sv
// constants shared by the spi status register bank
package ssb_pkg;

    // frame layout
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 12;
    localparam int unsigned FRAME_W = 16;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam int unsigned ADDR_LSB = 13;
    localparam int unsigned NORMAL_BIT = 12;

    // status register addresses
    localparam logic [2:0] ADDR_HEALTH = 3'h0;
    localparam logic [2:0] ADDR_GATE_LEVEL = 3'h1;
    localparam logic [2:0] ADDR_CH7 = 3'h2;
    localparam logic [2:0] ADDR_OVERLOAD = 3'h3;
    localparam logic [2:0] ADDR_CAL = 3'h4;
    localparam logic [2:0] ADDR_SWITCH_NODE = 3'h5;
    localparam logic [2:0] ADDR_UNUSED = 3'h6;
    localparam logic [2:0] ADDR_IDENT = 3'h7;

    // device health field positions
    localparam int unsigned TEST_BIT = 11;
    localparam int unsigned CLEARED_BIT = 10;
    localparam int unsigned FAILSAFE_BIT = 9;
    localparam int unsigned FRAME_ERR_BIT = 8;
    localparam int unsigned PUMP_LOW_BIT = 7;
    localparam int unsigned PUMP_FAIL_BIT = 6;
    localparam int unsigned UNDER_BIT = 5;
    localparam int unsigned OVER_BIT = 4;
    localparam int unsigned SUMMARY_BIT = 1;

    // channel 7 field positions
    localparam int unsigned CH7_HS_OVL_BIT = 3;
    localparam int unsigned CH7_LS_OVL_BIT = 2;
    localparam int unsigned CH7_HIGH_BIT = 1;
    localparam int unsigned CH7_LOW_BIT = 0;

    // calibration field positions
    localparam int unsigned CAL_READY_BIT = 8;
    localparam int unsigned RISE_DLY_LSB = 6;
    localparam int unsigned RISE_PC_LSB = 4;
    localparam int unsigned FALL_DLY_LSB = 2;
    localparam int unsigned FALL_PC_LSB = 0;

    // calibration result encodings
    localparam logic [1:0] RISE_DLY_BELOW_15 = 2'h0;
    localparam logic [1:0] RISE_DLY_15_85 = 2'h1;
    localparam logic [1:0] RISE_DLY_85_95 = 2'h2;
    localparam logic [1:0] RISE_DLY_ABOVE_95 = 2'h3;
    localparam logic [1:0] RISE_PC_BELOW_5 = 2'h0;
    localparam logic [1:0] RISE_PC_5_15 = 2'h1;
    localparam logic [1:0] RISE_PC_15_85 = 2'h2;
    localparam logic [1:0] RISE_PC_ABOVE_85 = 2'h3;
    localparam logic [1:0] FALL_DLY_ABOVE_85 = 2'h0;
    localparam logic [1:0] FALL_DLY_85_15 = 2'h1;
    localparam logic [1:0] FALL_DLY_15_5 = 2'h2;
    localparam logic [1:0] FALL_DLY_BELOW_5 = 2'h3;
    localparam logic [1:0] FALL_PC_ABOVE_95 = 2'h0;
    localparam logic [1:0] FALL_PC_95_85 = 2'h1;
    localparam logic [1:0] FALL_PC_85_15 = 2'h2;
    localparam logic [1:0] FALL_PC_BELOW_15 = 2'h3;

    // reset values
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [11:0] DATA_RESET = 12'h000;
    localparam logic [15:0] FRAME_RESET = 16'h0000;
    localparam logic [1:0] CAL_RESET = 2'h0;

    // number of latched health and overload flags
    localparam int unsigned HEALTH_W = 6;
    localparam int unsigned OVL_W = 14;

endpackage : ssb_pkg

// ### hw/ssb_sync.sv
// two flip-flop synchroniser for pin inputs
module ssb_sync #(
    parameter int unsigned W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : ssb_sync

// ### hw/ssb_flag_bank.sv
// bank of latched diagnostic flags, set beats clear
module ssb_flag_bank #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags
);

    // a flag holds until its cause is gone and it was read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= set | (flags & ~clr);
        end
    end

endmodule : ssb_flag_bank

// ### verif/ssb_status_bank_properties.sv
// port timing checker of the spi status register bank
module ssb_status_bank_properties (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDO,
    input wire logic SPI_SDO_OE,
    input wire logic PUMP_FAIL,
    input wire logic HIGH_SIDE_BLOCK,
    input wire logic [15:0] RX_WORD,
    input wire logic RX_STROBE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // sdo drive follows chip select
    property p_oe_start;
        $fell(SPI_CS_N) |-> ##[2:6] SPI_SDO_OE;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("sdo not driven at frame start");
    property p_oe_end;
        $rose(SPI_CS_N) |-> ##[1:8] !SPI_SDO_OE;
    endproperty
    a_oe_end: assert property (p_oe_end)
        else $error("sdo still driven after frame");
    property p_idle;
        SPI_CS_N [*8] |-> !SPI_SDO_OE && !SPI_SDO;
    endproperty
    a_idle: assert property (p_idle)
        else $error("sdo active while idle");
    // bits move only while the link clock is low
    property p_sdo_move;
        $changed(SPI_SDO) && $past(SPI_SDO_OE) |-> !SPI_SCLK;
    endproperty
    a_sdo_move: assert property (p_sdo_move)
        else $error("sdo moved with clock high");
    // pump failure blocks the high side
    property p_block_set;
        $rose(PUMP_FAIL) |-> ##[1:3] HIGH_SIDE_BLOCK;
    endproperty
    a_block_set: assert property (p_block_set)
        else $error("high side not blocked");
    property p_block_hold;
        HIGH_SIDE_BLOCK && PUMP_FAIL |=> HIGH_SIDE_BLOCK;
    endproperty
    a_block_hold: assert property (p_block_hold)
        else $error("block dropped with cause present");
    // received word handshake
    property p_strobe_one;
        RX_STROBE |=> !RX_STROBE;
    endproperty
    a_strobe_one: assert property (p_strobe_one)
        else $error("strobe longer than one cycle");
    property p_rx_hold;
        $changed(RX_WORD) |-> RX_STROBE;
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("word changed without strobe");
    c_frame: cover property ($rose(SPI_SDO_OE));
    c_word: cover property (RX_STROBE);
    c_block: cover property ($rose(HIGH_SIDE_BLOCK));
endmodule : ssb_status_bank_properties

bind ssb_status_bank ssb_status_bank_properties u_props (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .SPI_SCLK(SPI_SCLK),
    .SPI_CS_N(SPI_CS_N), .SPI_SDO(SPI_SDO), .SPI_SDO_OE(SPI_SDO_OE),
    .PUMP_FAIL(PUMP_FAIL), .HIGH_SIDE_BLOCK(HIGH_SIDE_BLOCK),
    .RX_WORD(RX_WORD), .RX_STROBE(RX_STROBE)
);

// ### verif/ssb_spi_host.sv
// host model: mode 0 spi master of sixteen bit frames
module ssb_spi_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // link idle: clock low, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // n clocks msb first, sdo taken on each rise
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        #62.5;
        for (int i = 0; i < n; i++) begin
            sdi = tx[15 - (i % 16)];
            #62.5 sclk = 1'b1;
            rx = {rx[14:0], sdo};
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        sdi = ~sdi; // released line keeps no stale value
        #400;
    endtask : xfer
endmodule : ssb_spi_host

// ### verif/test_ssb_status_bank.sv
// self-checking bench of the spi status register bank
module test_ssb_status_bank;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] ID = 12'hA5C; // arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, sclk, cs_n, sdi, sdo, oe, hsb, stb;
    logic fs, nmode, tmode, pl, pf, un, ov, cd, hold, wr, nmode_d, m_fe;
    logic m_cr, m_hold, m_clrd;
    logic [6:0] gh, gl, hso, lso, m_oh, m_ol;
    logic [7:0] cc, m_cc;
    logic [11:0] ost;
    logic [3:0] m_hl;
    logic [2:0] sel, m_sel;
    logic [15:0] rxw;
    logic [31:0] seed = 32'h9807;
    int n_fail = 0, compares = 0, n_stb = 0;

    always #4 clk = ~clk;

    ssb_status_bank #(.DEVICE_ID(ID)) u_dut (
        .CLOCK(clk), .RESET_N(rst_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
        .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(oe), .FAILSAFE_PIN(fs),
        .NORMAL_MODE(nmode), .TEST_MODE(tmode), .PUMP_LOW(pl), .PUMP_FAIL(pf),
        .SUPPLY_UNDER(un), .SUPPLY_OVER(ov), .GATE_HIGH(gh), .GATE_LOW(gl),
        .HIGH_SIDE_OVERLOAD(hso), .LOW_SIDE_OVERLOAD(lso), .CAL_DONE(cd),
        .CAL_RISE_DELAY(cc[7:6]), .CAL_RISE_PRECHARGE(cc[5:4]),
        .CAL_FALL_DELAY(cc[3:2]), .CAL_FALL_PRECHARGE(cc[1:0]),
        .OUTPUT_STATUS(ost), .STATUS_SELECT(sel), .STATUS_SELECT_HOLD(hold),
        .STATUS_SELECT_WR(wr), .HIGH_SIDE_BLOCK(hsb), .RX_WORD(rxw),
        .RX_STROBE(stb)
    );
    ssb_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // model: causes latch, normal entry and calibration set flags
    always @(posedge clk) begin
        if (!rst_n) begin
            {m_hl, m_fe, m_clrd, m_cr, nmode_d} = 8'h00;
            {m_oh, m_ol, m_cc} = 22'h0;
        end else begin
            m_hl |= {pl, pf, un, ov};
            m_oh |= hso;
            m_ol |= lso;
            m_clrd |= nmode & ~nmode_d;
            if (cd) m_cc = cc;
            m_cr |= cd;
            nmode_d = nmode;
        end
        if (stb === 1'b1) n_stb++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // model: twelve data bits of a register
    function automatic logic [11:0] exp_data(input logic [2:0] a);
        logic [11:0] d;
        d = 12'h000;
        case (a)
            3'h0: d = {tmode, m_clrd, fs, m_fe, m_hl, 2'h0,
                       |{m_oh, m_ol}, 1'b0};
            3'h1: for (int i = 0; i < 6; i++) d[2*i +: 2] = {gh[i], gl[i]};
            3'h2: d[3:0] = {m_oh[6], m_ol[6], gh[6], gl[6]};
            3'h3: for (int i = 0; i < 6; i++) d[2*i +: 2] = {m_oh[i], m_ol[i]};
            3'h4: d = {3'h0, m_cr, m_cc};
            3'h5: d = ost;
            3'h7: d = tmode ? 12'h000 : ID;
            default: d = 12'h000;
        endcase
        return d;
    endfunction : exp_data

    // model: flags read as one clear unless the cause remains
    task automatic clear(input logic [11:0] d);
        case (m_sel)
            3'h0: begin
                m_clrd &= ~d[10];
                m_fe &= ~d[8];
                m_hl = m_hl & ~d[7:4] | {pl, pf, un, ov};
            end
            3'h2: begin
                m_oh[6] = m_oh[6] & ~d[3] | hso[6];
                m_ol[6] = m_ol[6] & ~d[2] | lso[6];
            end
            3'h3: for (int i = 0; i < 6; i++) begin
                m_oh[i] = m_oh[i] & ~d[2*i+1] | hso[i];
                m_ol[i] = m_ol[i] & ~d[2*i] | lso[i];
            end
            3'h4: m_cr &= ~d[8];
            default: ;
        endcase
    endtask : clear

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // register selection for following frames
    task automatic pick(input logic [2:0] a, input logic h);
        step(1);
        sel = a;
        hold = h;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        m_sel = a;
        m_hold = h;
    endtask : pick

    // one frame of n clocks against the model
    task automatic rd(input int n);
        logic [15:0] tx, rx, ex;
        int s0;
        tx = 16'(rnd());
        ex = {m_sel, nmode, exp_data(m_sel)};
        s0 = n_stb;
        u_host.xfer(tx, n, rx);
        check("strobes", 16'(n_stb - s0), 16'(n == 16));
        if (n == 16) begin
            check("frame", rx, ex);
            check("rx word", rxw, tx);
            clear(ex[11:0]);
            if (!m_hold) m_sel = 3'h0;
        end else begin
            m_fe = 1'b1;
        end
        step(1);
    endtask : rd

    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        #500000;
        n_fail++;
        stop_test();
    end

    initial begin
        {fs, nmode, tmode, pl, pf, un, ov, cd, hold, wr} = 10'h000;
        {gh, gl, hso, lso, cc, ost, sel} = 51'h0;
        m_sel = 3'h0;
        m_hold = 1'b0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        step(4);
        rd(16);
        nmode = 1'b1;
        step(3);
        rd(16);
        rd(16);
        // live pins, one-cycle faults, supply over kept
        {tmode, fs, pl, pf, un, ov} = 6'h3F;
        step(1);
        {pl, pf, un} = 3'h0;
        step(3);
        check("block", {15'h0, hsb}, 16'h0001);
        rd(16);
        rd(16);
        check("block", {15'h0, hsb}, 16'h0000);
        {tmode, fs, ov} = 3'h0;
        step(3);
        rd(16);
        // every address, random levels, one-cycle overloads
        for (int k = 0; k < 16; k++) begin
            {gl, gh} = 14'(rnd());
            {lso, hso} = 14'(rnd());
            ost = 12'(rnd());
            tmode = k[3];
            step(1);
            {lso, hso} = 14'h0;
            pick(3'(k), 1'b0);
            rd(16);
            rd(16);
        end
        // every result code per field, held selection
        for (int c = 0; c < 4; c++) begin
            cc = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)};
            cd = 1'b1;
            step(1);
            cd = 1'b0;
            pick(3'h4, 1'b1);
            rd(16);
            rd(16);
        end
        // short and long frames are refused
        pick(3'h2, 1'b0);
        rd(15);
        rd(17);
        rd(16);
        rd(16);
        rd(16);
        stop_test();
    end
endmodule : test_ssb_status_bank
